// File: src/pmc_pkg.sv
package pmc_pkg;

    // operating modes, one-hot
    typedef enum logic [5:0] {
        PMC_RUN      = 6'h01,
        PMC_VLP_RUN  = 6'h02,
        PMC_WAIT     = 6'h04,
        PMC_VLP_WAIT = 6'h08,
        PMC_STOP     = 6'h10,
        PMC_VLP_STOP = 6'h20
    } pmc_mode_t;

    // peripheral clock enable vector bit positions
    localparam int PMC_PERIPH_W = 12;
    localparam int PMC_B_CONVERTER = 0;
    localparam int PMC_B_COMPARATOR = 1;
    localparam int PMC_B_LP_TIMER = 2;
    localparam int PMC_B_PIN_IRQ = 3;
    localparam int PMC_B_OSC = 4;
    localparam int PMC_B_PERIODIC = 5;
    localparam int PMC_B_FLEX_SERIAL = 6;
    localparam int PMC_B_ASYNC_SERIAL = 7;
    localparam int PMC_B_TWO_WIRE = 8;
    localparam int PMC_B_FOUR_WIRE = 9;
    localparam int PMC_B_DMA = 10;
    localparam int PMC_B_OTHER = 11;

    localparam logic [11:0] PMC_GATES_ALL = 12'hFFF;
    localparam logic [11:0] PMC_GATES_STOP = 12'h00F;
    localparam logic [11:0] PMC_GATES_VLP_STOP = 12'h7F7;

    // stop-entry clock handshake guard: cycles in stop before a wake is honoured
    localparam int PMC_STOP_SETTLE_NS = 80;
    localparam int PMC_CLK_PERIOD_NS = 40;
    localparam logic [3:0] PMC_STOP_SETTLE_CYC =
        4'((PMC_STOP_SETTLE_NS + PMC_CLK_PERIOD_NS - 1) / PMC_CLK_PERIOD_NS);

endpackage

// File: src/pmc_wake_sync.sv
`timescale 1ns/1ps
// wake request collector: enabled pin events plus other wake sources
module pmc_wake_sync
    import pmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] pin_irq,
    input wire logic [7:0] pin_irq_en,
    input wire logic periph_wake,
    input wire logic armed,
    output logic wake
);
    logic wake_q;

    // any enabled pin interrupt or peripheral wake source; held until stop is
    // left so that a short event inside the settle time is not lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= armed && (wake_q || (|(pin_irq & pin_irq_en)) || periph_wake);
        end
    end

    assign wake = wake_q;
endmodule

// File: src/pmc_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - sleep instruction enters wait-class or stop-class mode per configuration
// - run and low-power run keep core active with all peripherals
// - run mode keeps every module clocked
// - low-power run: reduced frequency, voltage monitor off
// - wait modes: core sleeps, peripherals may run as programmed
// - wait mode: all peripherals operational, core asleep
// - low-power wait: reduced frequency, voltage monitor off, core asleep
// - stop modes disable core; stop gates most peripherals, low-power stop gates only pin irq and other; register retention per configuration in low-power stop only
// - stop: most clocks gated, registers and sram kept, voltage monitor on
// - stop: converter, comparator, timer, pins run; wake via async controller
// - low-power stop: listed peripherals run; voltage monitor, interrupt controller off
// - interrupt controller wakes core from wait modes
// - async wake controller wakes core from stop modes
// - async controller restarts clocks, then interrupt controller handles pending
// - any enabled pin interrupt wakes from stop modes
module pmc_ctrl
    import pmc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CFG_WR,
    input wire logic CFG_DEEP,
    input wire logic CFG_LOW_POWER,
    input wire logic CFG_SRAM_RETAIN,
    input wire logic SLEEP_REQ,
    input wire logic IRQ_PENDING,
    input wire logic [7:0] PIN_IRQ,
    input wire logic [7:0] PIN_IRQ_EN,
    input wire logic PERIPH_WAKE,
    output logic [5:0] MODE,
    output logic CORE_CLK_EN,
    output logic CORE_SLEEPING,
    output logic REDUCED_FREQ,
    output logic VOLT_MON_EN,
    output logic PRIO_IRQ_EN,
    output logic ASYNC_WAKE_EN,
    output logic SYS_CLK_RESUME,
    output logic SRAM_RETAIN,
    output logic REG_RETAIN,
    output logic [11:0] PERIPH_CLK_EN
);
    pmc_mode_t mode_q, mode_d;
    logic cfg_deep_q, cfg_lp_q, cfg_ret_q;
    logic [3:0] settle_q;
    logic wake_async;
    logic resume_q;
    logic [11:0] gates_q;
    logic reduced_q, volt_q, prio_q, awake_q, core_q, sleep_q, sram_q, reg_q;

    function automatic logic mode_is_stop(input pmc_mode_t m);
        return (m == PMC_STOP) || (m == PMC_VLP_STOP);
    endfunction

    function automatic logic mode_is_wait(input pmc_mode_t m);
        return (m == PMC_WAIT) || (m == PMC_VLP_WAIT);
    endfunction

    // stored configuration, written whenever CFG_WR is high, in any mode
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_deep_q <= 1'b0;
            cfg_lp_q <= 1'b0;
            cfg_ret_q <= 1'b1;
        end else if (CFG_WR) begin
            cfg_deep_q <= CFG_DEEP;
            cfg_lp_q <= CFG_LOW_POWER;
            cfg_ret_q <= CFG_SRAM_RETAIN;
        end
    end

    pmc_wake_sync u_wake (
        .clk(MCLK),
        .rst_n(RST_N),
        .pin_irq(PIN_IRQ),
        .pin_irq_en(PIN_IRQ_EN),
        .periph_wake(PERIPH_WAKE),
        .armed(mode_is_stop(mode_q)),
        .wake(wake_async)
    );

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            PMC_RUN, PMC_VLP_RUN: begin
                if (SLEEP_REQ) begin
                    // deep and low-power configuration sampled in one cycle
                    if (cfg_deep_q) begin
                        mode_d = cfg_lp_q ? PMC_VLP_STOP : PMC_STOP;
                    end else begin
                        mode_d = cfg_lp_q ? PMC_VLP_WAIT : PMC_WAIT;
                    end
                end else begin
                    mode_d = cfg_lp_q ? PMC_VLP_RUN : PMC_RUN;
                end
            end
            PMC_WAIT: begin
                if (IRQ_PENDING) mode_d = PMC_RUN;
            end
            PMC_VLP_WAIT: begin
                if (IRQ_PENDING) mode_d = PMC_VLP_RUN;
            end
            PMC_STOP: begin
                if (wake_async && settle_q == 4'h0) mode_d = PMC_RUN;
            end
            PMC_VLP_STOP: begin
                if (wake_async && settle_q == 4'h0) mode_d = PMC_VLP_RUN;
            end
            default: mode_d = PMC_RUN;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q <= PMC_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // minimum stop residency before a wake is honoured
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            settle_q <= 4'h0;
        end else if (!mode_is_stop(mode_q) && mode_is_stop(mode_d)) begin
            settle_q <= PMC_STOP_SETTLE_CYC;
        end else if (settle_q != 4'h0) begin
            settle_q <= settle_q - 4'h1;
        end
    end

    // clock resume pulse on leaving stop; pending irq then seen by controller
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= mode_is_stop(mode_q) && !mode_is_stop(mode_d);
        end
    end

    // per-mode outputs, registered from next mode
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            gates_q <= PMC_GATES_ALL;
            reduced_q <= 1'b0;
            volt_q <= 1'b1;
            prio_q <= 1'b1;
            awake_q <= 1'b0;
            core_q <= 1'b1;
            sleep_q <= 1'b0;
            sram_q <= 1'b1;
            reg_q <= 1'b1;
        end else begin
            unique case (mode_d)
                PMC_RUN: begin
                    gates_q <= PMC_GATES_ALL;
                    reduced_q <= 1'b0;
                    volt_q <= 1'b1;
                    prio_q <= 1'b1;
                    awake_q <= 1'b0;
                    core_q <= 1'b1;
                    sleep_q <= 1'b0;
                    sram_q <= 1'b1;
                    reg_q <= 1'b1;
                end
                PMC_VLP_RUN: begin
                    gates_q <= PMC_GATES_ALL;
                    reduced_q <= 1'b1;
                    volt_q <= 1'b0;
                    prio_q <= 1'b1;
                    awake_q <= 1'b0;
                    core_q <= 1'b1;
                    sleep_q <= 1'b0;
                    sram_q <= 1'b1;
                    reg_q <= 1'b1;
                end
                PMC_WAIT: begin
                    gates_q <= PMC_GATES_ALL;
                    reduced_q <= 1'b0;
                    volt_q <= 1'b1;
                    prio_q <= 1'b1;
                    awake_q <= 1'b0;
                    core_q <= 1'b0;
                    sleep_q <= 1'b1;
                    sram_q <= 1'b1;
                    reg_q <= 1'b1;
                end
                PMC_VLP_WAIT: begin
                    gates_q <= PMC_GATES_ALL;
                    reduced_q <= 1'b1;
                    volt_q <= 1'b0;
                    prio_q <= 1'b1;
                    awake_q <= 1'b0;
                    core_q <= 1'b0;
                    sleep_q <= 1'b1;
                    sram_q <= 1'b1;
                    reg_q <= 1'b1;
                end
                PMC_STOP: begin
                    gates_q <= PMC_GATES_STOP;
                    reduced_q <= 1'b0;
                    volt_q <= 1'b1;
                    prio_q <= 1'b0;
                    awake_q <= 1'b1;
                    core_q <= 1'b0;
                    sleep_q <= 1'b1;
                    sram_q <= 1'b1;
                    reg_q <= 1'b1;
                end
                PMC_VLP_STOP: begin
                    gates_q <= PMC_GATES_VLP_STOP;
                    reduced_q <= 1'b1;
                    volt_q <= 1'b0;
                    prio_q <= 1'b0;
                    awake_q <= 1'b1;
                    core_q <= 1'b0;
                    sleep_q <= 1'b1;
                    sram_q <= 1'b1;
                    reg_q <= cfg_ret_q;
                end
                default: begin
                    gates_q <= PMC_GATES_ALL;
                    reduced_q <= 1'b0;
                    volt_q <= 1'b1;
                    prio_q <= 1'b1;
                    awake_q <= 1'b0;
                    core_q <= 1'b1;
                    sleep_q <= 1'b0;
                    sram_q <= 1'b1;
                    reg_q <= 1'b1;
                end
            endcase
        end
    end

    assign MODE = mode_q;
    assign PERIPH_CLK_EN = gates_q;
    assign REDUCED_FREQ = reduced_q;
    assign VOLT_MON_EN = volt_q;
    assign PRIO_IRQ_EN = prio_q;
    assign ASYNC_WAKE_EN = awake_q;
    assign CORE_CLK_EN = core_q;
    assign CORE_SLEEPING = sleep_q;
    assign SRAM_RETAIN = sram_q;
    assign REG_RETAIN = reg_q;
    assign SYS_CLK_RESUME = resume_q;

    sequence s_sleep_deep;
        SLEEP_REQ && cfg_deep_q && (mode_q == PMC_RUN || mode_q == PMC_VLP_RUN);
    endsequence

    sequence s_sleep_wait;
        SLEEP_REQ && !cfg_deep_q && (mode_q == PMC_RUN || mode_q == PMC_VLP_RUN);
    endsequence

    a_enter_stop_class: assert property (@(posedge MCLK) disable iff (!RST_N)
        s_sleep_deep |=> mode_is_stop(mode_q) && !CORE_CLK_EN)
        else $error("sleep with deep config did not enter stop");

    a_enter_wait_class: assert property (@(posedge MCLK) disable iff (!RST_N)
        s_sleep_wait |=> mode_is_wait(mode_q) && CORE_SLEEPING)
        else $error("sleep with wait config did not enter wait");

    a_run_all_clocks: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode_q == PMC_RUN |-> PERIPH_CLK_EN == PMC_GATES_ALL && CORE_CLK_EN)
        else $error("run mode not fully clocked");

    a_vlp_monitor_off: assert property (@(posedge MCLK) disable iff (!RST_N)
        (mode_q == PMC_VLP_RUN || mode_q == PMC_VLP_WAIT) |-> !VOLT_MON_EN && REDUCED_FREQ)
        else $error("low-power mode kept monitor on");

    a_stop_gating: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode_q == PMC_STOP |-> PERIPH_CLK_EN == PMC_GATES_STOP && VOLT_MON_EN && SRAM_RETAIN)
        else $error("stop gating or retention wrong");

    a_stop_wake_ctrl: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode_is_stop(mode_q) |-> ASYNC_WAKE_EN && !PRIO_IRQ_EN)
        else $error("stop mode wake controller selection wrong");

    a_wait_irq_exit: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode_is_wait(mode_q) && IRQ_PENDING |=> CORE_CLK_EN && !CORE_SLEEPING)
        else $error("pending irq did not wake from wait");

    a_stop_resume: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode_is_stop(mode_q) ##1 !mode_is_stop(mode_q) |-> SYS_CLK_RESUME)
        else $error("clock resume not signalled");

    a_pin_wake: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode_is_stop(mode_q) && (|(PIN_IRQ & PIN_IRQ_EN)) |-> ##[1:6] !mode_is_stop(mode_q))
        else $error("enabled pin interrupt failed to wake");

    sequence s_stop_entry;
        !mode_is_stop(mode_q) ##1 mode_is_stop(mode_q);
    endsequence

    // a wake already pending at entry is held off for the settle time
    a_stop_settle: assert property (@(posedge MCLK) disable iff (!RST_N)
        s_stop_entry |=> mode_is_stop(mode_q) [*2])
        else $error("stop left before settle time");

    a_vlp_stop_gating: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode_q == PMC_VLP_STOP |-> PERIPH_CLK_EN == PMC_GATES_VLP_STOP
            && !VOLT_MON_EN && !PRIO_IRQ_EN && SRAM_RETAIN)
        else $error("low-power stop gating wrong");

    a_wait_all_clocks: assert property (@(posedge MCLK) disable iff (!RST_N)
        mode_is_wait(mode_q) |-> PERIPH_CLK_EN == PMC_GATES_ALL
            && !CORE_CLK_EN && CORE_SLEEPING)
        else $error("wait mode clocking wrong");
endmodule

// File: bench/pmc_core_model.sv
`timescale 1ns/1ps
// processor core issuing sleep instructions, plus the wake sources around it
module pmc_core_model (
    input wire logic clk,
    input wire logic core_sleeping,
    output logic sleep_req,
    output logic irq_pending,
    output logic [7:0] pin_irq,
    output logic [7:0] pin_irq_en,
    output logic periph_wake
);
    initial begin
        sleep_req = 1'b0;
        irq_pending = 1'b0;
        pin_irq = 8'h00;
        pin_irq_en = 8'h00;
        periph_wake = 1'b0;
    end

    // a sleeping core cannot execute another sleep instruction
    task automatic sleep_instr();
        @(negedge clk);
        if (core_sleeping !== 1'b1) begin
            sleep_req = 1'b1;
        end
        @(negedge clk);
        sleep_req = 1'b0;
    endtask

    // sources hold their levels until told otherwise
    task automatic set_wake(input logic irq, input logic [7:0] pins, input logic [7:0] en,
                            input logic pw);
        @(negedge clk);
        irq_pending = irq;
        pin_irq = pins;
        pin_irq_en = en;
        periph_wake = pw;
    endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import pmc_pkg::*;
;
    logic mclk, rst_n, cfg_wr, cfg_deep, cfg_lp, cfg_ret;
    logic sleep_req, irq_pending, periph_wake;
    logic [7:0] pin_irq, pin_irq_en;
    logic [5:0] mode;
    logic core_clk_en, core_sleeping, reduced_freq, volt_mon_en, prio_irq_en;
    logic async_wake_en, sys_clk_resume, sram_retain, reg_retain;
    logic [11:0] periph_clk_en;
    int mismatches, checked;

    pmc_ctrl uut (.MCLK(mclk), .RST_N(rst_n), .CFG_WR(cfg_wr), .CFG_DEEP(cfg_deep),
        .CFG_LOW_POWER(cfg_lp), .CFG_SRAM_RETAIN(cfg_ret), .SLEEP_REQ(sleep_req),
        .IRQ_PENDING(irq_pending), .PIN_IRQ(pin_irq), .PIN_IRQ_EN(pin_irq_en),
        .PERIPH_WAKE(periph_wake), .MODE(mode), .CORE_CLK_EN(core_clk_en),
        .CORE_SLEEPING(core_sleeping), .REDUCED_FREQ(reduced_freq),
        .VOLT_MON_EN(volt_mon_en), .PRIO_IRQ_EN(prio_irq_en), .ASYNC_WAKE_EN(async_wake_en),
        .SYS_CLK_RESUME(sys_clk_resume), .SRAM_RETAIN(sram_retain), .REG_RETAIN(reg_retain),
        .PERIPH_CLK_EN(periph_clk_en));

    pmc_core_model core (.clk(mclk), .core_sleeping(core_sleeping), .sleep_req(sleep_req),
        .irq_pending(irq_pending), .pin_irq(pin_irq), .pin_irq_en(pin_irq_en),
        .periph_wake(periph_wake));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic final_report();
        $display("counts: %0d checks, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_mode(input logic [5:0] exp, input int bound);
        int n;
        n = 0;
        while (mode !== exp && n < bound) begin
            @(negedge mclk);
            n++;
        end
        if (mode !== exp) begin
            mismatches++;
            $display("wrong value mode: expected %h, seen %h", exp, mode);
            final_report();
        end
    endtask

    // outs: core clock, voltage monitor, priority irq, async wake, sram, registers
    task automatic chk_state(input logic [5:0] m, input logic [5:0] outs,
                             input logic [11:0] gates, input logic [1:0] sr);
        check("mode", 12'(mode), 12'(m));
        check("mode outputs", 12'({core_clk_en, volt_mon_en, prio_irq_en, async_wake_en,
            sram_retain, reg_retain}), 12'(outs));
        check("peripheral clocks", periph_clk_en, gates);
        check("sleep and frequency", 12'({core_sleeping, reduced_freq}), 12'(sr));
    endtask

    task automatic cfg(input logic deep, input logic lp, input logic ret);
        @(negedge mclk);
        cfg_deep = deep;
        cfg_lp = lp;
        cfg_ret = ret;
        cfg_wr = 1'b1;
        @(negedge mclk);
        cfg_wr = 1'b0;
    endtask

    task automatic t_reset();
        chk_state(PMC_RUN, 6'h3B, PMC_GATES_ALL, 2'h0);
        $display("test reset done");
    endtask

    task automatic t_wait();
        // config written in the same cycle as the sleep instruction is not yet in force
        fork
            cfg(1'b1, 1'b0, 1'b1);
            core.sleep_instr();
        join
        chk_state(PMC_WAIT, 6'h1B, PMC_GATES_ALL, 2'h2);
        core.set_wake(1'b0, 8'h01, 8'h01, 1'b1);
        repeat (4) @(negedge mclk);
        check("mode", 12'(mode), 12'(PMC_WAIT));
        core.set_wake(1'b1, 8'h00, 8'h00, 1'b0);
        wait_mode(PMC_RUN, 2);
        core.set_wake(1'b0, 8'h00, 8'h00, 1'b0);
        chk_state(PMC_RUN, 6'h3B, PMC_GATES_ALL, 2'h0);
        $display("test wait done");
    endtask

    task automatic t_stop();
        int pulses;
        pulses = 0;
        core.sleep_instr();
        chk_state(PMC_STOP, 6'h17, PMC_GATES_STOP, 2'h2);
        core.set_wake(1'b1, 8'h80, 8'h7F, 1'b0);
        repeat (6) @(negedge mclk);
        check("mode", 12'(mode), 12'(PMC_STOP));
        core.set_wake(1'b0, 8'h80, 8'h80, 1'b0);
        wait_mode(PMC_RUN, 6);
        repeat (3) begin
            if (sys_clk_resume === 1'b1) begin
                pulses++;
            end
            @(negedge mclk);
        end
        check("clock resume pulses", 12'(pulses), 12'h001);
        core.set_wake(1'b0, 8'h00, 8'h00, 1'b0);
        // wake already pending at entry is held off for the settle time
        core.set_wake(1'b0, 8'h00, 8'h00, 1'b1);
        core.sleep_instr();
        check("mode", 12'(mode), 12'(PMC_STOP));
        @(negedge mclk);
        check("mode", 12'(mode), 12'(PMC_STOP));
        wait_mode(PMC_RUN, 3);
        core.set_wake(1'b0, 8'h00, 8'h00, 1'b0);
        $display("test stop done");
    endtask

    task automatic t_vlp();
        cfg(1'b1, 1'b1, 1'b0);
        wait_mode(PMC_VLP_RUN, 3);
        chk_state(PMC_VLP_RUN, 6'h2B, PMC_GATES_ALL, 2'h1);
        core.sleep_instr();
        chk_state(PMC_VLP_STOP, 6'h06, PMC_GATES_VLP_STOP, 2'h3);
        core.set_wake(1'b0, 8'h00, 8'h00, 1'b1);
        wait_mode(PMC_VLP_RUN, 6);
        core.set_wake(1'b0, 8'h00, 8'h00, 1'b0);
        cfg(1'b0, 1'b1, 1'b1);
        core.sleep_instr();
        chk_state(PMC_VLP_WAIT, 6'h0B, PMC_GATES_ALL, 2'h3);
        core.set_wake(1'b1, 8'h00, 8'h00, 1'b0);
        wait_mode(PMC_VLP_RUN, 2);
        core.set_wake(1'b0, 8'h00, 8'h00, 1'b0);
        cfg(1'b0, 1'b0, 1'b1);
        wait_mode(PMC_RUN, 3);
        chk_state(PMC_RUN, 6'h3B, PMC_GATES_ALL, 2'h0);
        $display("test low power done");
    endtask

    task automatic t_reset_in_stop();
        cfg(1'b1, 1'b0, 1'b1);
        core.sleep_instr();
        check("mode", 12'(mode), 12'(PMC_STOP));
        @(negedge mclk);
        rst_n = 1'b0;
        @(negedge mclk);
        chk_state(PMC_RUN, 6'h3B, PMC_GATES_ALL, 2'h0);
        rst_n = 1'b1;
        // configuration is back at its reset value, so a sleep now waits
        core.sleep_instr();
        check("mode", 12'(mode), 12'(PMC_WAIT));
        check("clock resume", 12'(sys_clk_resume), 12'h000);
        core.set_wake(1'b1, 8'h00, 8'h00, 1'b0);
        wait_mode(PMC_RUN, 2);
        core.set_wake(1'b0, 8'h00, 8'h00, 1'b0);
        $display("test reset in stop done");
    endtask

    initial begin
        mismatches = 0;
        checked = 0;
        rst_n = 1'b0;
        cfg_wr = 1'b0;
        cfg_deep = 1'b0;
        cfg_lp = 1'b0;
        cfg_ret = 1'b1;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_wait();
        t_stop();
        t_vlp();
        t_reset_in_stop();
        final_report();
    end
endmodule
